// ==== pkg/frl_pkg.sv ====
// frl_pkg: shared constants, command codes and carriers for the fault record block.
// assumes a command-level front end (decoded bus transactions) on the same clock.
package frl_pkg;

    // command codes
    localparam logic [7:0] CMD_UNLOCK = 8'hBD;
    localparam logic [7:0] CMD_ERASE = 8'hBE;
    localparam logic [7:0] CMD_DATA = 8'hBF;
    localparam logic [7:0] CMD_LOG_CLEAR = 8'hEC;
    localparam logic [7:0] CMD_LOG_STORE = 8'hEA;

    // log source codes
    localparam logic [7:0] SRC_MANUAL = 8'hFF;
    localparam logic [7:0] SRC_CH0_LAST = 8'h0A;
    localparam logic [7:0] SRC_CH1_BASE = 8'h10;
    localparam logic [7:0] SRC_CH1_LAST = 8'h1A;
    localparam logic [7:0] SRC_NONE = 8'h00;

    // die temperature gate, whole degrees c
    localparam logic signed [15:0] TEMP_OFF_C = 16'sh0082;
    localparam logic signed [15:0] TEMP_ON_C = 16'sh007D;

    // log layout
    localparam int LOG_PAGES = 6;
    localparam logic [2:0] LOG_LAST_IDX = 3'h5;
    localparam logic [2:0] LOG_FIRST_IDX = 3'h0;
    localparam int PAGE_BYTES = 20;
    localparam int PAGE_BITS = 160;
    localparam logic [7:0] LOG_PAGE0_BASE = 8'h1B;
    localparam logic [7:0] LOG_LAST_BYTE = 8'h92;
    localparam logic [7:0] LOG_HDR_SRC_BYTE = 8'h00;
    localparam int MFR_LOG_PRESENT_BIT = 3;

    // word and byte values
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [15:0] REFUSED_WORD = 16'h0000;
    localparam logic [7:0] EMPTY_BYTE = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ERASE = 2'b01,
        ST_CLEAR = 2'b10,
        ST_RESP = 2'b11
    } frl_state_t;

    // one event page, first field is log byte 0 of the page
    typedef struct packed {
        logic [15:0] vout0;
        logic [15:0] vout1;
        logic [15:0] iout0;
        logic [15:0] iout1;
        logic [15:0] vin;
        logic [15:0] iin;
        logic [7:0] status_vout0;
        logic [7:0] status_vout1;
        logic [15:0] status_word0;
        logic [15:0] status_word1;
        logic [7:0] status_mfr0;
        logic [7:0] status_mfr1;
    } frl_page_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } frl_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } frl_rsp_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
    } frl_logrd_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } frl_logbyte_t;

endpackage

// ==== src/frl_mem.sv ====
// frl_mem: simple two-port memory, one write port, registered read data.
// assumes the owner never needs read-during-write bypass.
`timescale 1ns/100ps
`default_nettype none
module frl_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 64
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    if (WIDTH < 1 || DEPTH < 2) begin : g_chk
        $error("frl_mem: bad geometry");
    end

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule // frl_mem
`default_nettype wire

// ==== src/frl_top.sv ====
// frl_top: fault record capture and user memory access behind command codes.
// assumes CMD_I, PASS_DONE_I, FAULT_I and DIE_TEMP_I come from logic on CLK_I.
`timescale 1ns/100ps
`default_nettype none
module frl_top
    import frl_pkg::*;
#(
    parameter int USER_WORDS = 64
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire frl_cmd_t CMD_I,
    output frl_rsp_t RSP_O,
    output logic BUSY_O,
    input wire logic signed [15:0] DIE_TEMP_I,
    input wire logic PASS_DONE_I,
    input wire frl_page_t PAGE_I,
    input wire logic FAULT_I,
    input wire logic [7:0] FAULT_CODE_I,
    input wire frl_logrd_t LOG_RD_I,
    output frl_logbyte_t LOG_O,
    output logic [7:0] MFR_STATUS_O,
    output logic NVM_BLOCKED_O
);
    localparam int AW = $clog2(USER_WORDS);
    localparam logic [AW-1:0] LAST_WORD = AW'(USER_WORDS - 1);

    // sweep counter also walks the log pages, so it needs at least 3 bits
    if (USER_WORDS < 8 || USER_WORDS > 65536 || (1 << AW) != USER_WORDS) begin : g_chk
        $error("frl_top: USER_WORDS must be a power of two from 8 to 65536");
    end

    function automatic logic src_known(input logic [7:0] c);
        return (c <= SRC_CH0_LAST) || (c >= SRC_CH1_BASE && c <= SRC_CH1_LAST);
    endfunction

    function automatic logic [2:0] ring_next(input logic [2:0] p);
        return (p == LOG_LAST_IDX) ? LOG_FIRST_IDX : p + 3'h1;
    endfunction

    // page written "back" passes before the newest one
    function automatic logic [2:0] ring_back(input logic [2:0] wp, input logic [2:0] back);
        int t;
        t = int'(wp) + LOG_PAGES - 1 - int'(back);
        return 3'(t % LOG_PAGES);
    endfunction

    function automatic logic [7:0] page_byte(input frl_page_t p, input logic [4:0] j);
        logic [PAGE_BITS-1:0] v;
        v = p;
        return v[(PAGE_BITS - 1) - 8 * int'(j) -: 8];
    endfunction

    // control group
    frl_state_t state_ff, nxt_state;
    logic unlock_ff, nxt_unlock;
    logic [AW-1:0] ptr_ff, nxt_ptr;
    logic [AW-1:0] sweep_ff, nxt_sweep;
    logic [7:0] rcode_ff, nxt_rcode;
    logic rok_ff, nxt_rok;
    frl_rsp_t rsp_ff, nxt_rsp;
    logic busy_ff, nxt_busy;
    logic store_go;
    logic u_we;
    logic [AW-1:0] u_waddr;
    logic [15:0] u_wdata;
    logic [15:0] u_rdata;
    // temperature group
    logic hot_ff, nxt_hot;
    // log group
    logic [2:0] lwp_ff, nxt_lwp;
    logic frozen_ff, nxt_frozen;
    logic pend_ff, nxt_pend;
    logic present_ff, nxt_present;
    logic [7:0] src_ff, nxt_src;
    logic l_we;
    logic [2:0] l_waddr;
    frl_page_t l_wdata;
    frl_page_t l_rdata;
    // log read group
    logic [2:0] l_raddr;
    logic lrv_ff, nxt_lrv;
    logic lin_ff, nxt_lin;
    logic lhdr_ff, nxt_lhdr;
    logic [4:0] lj_ff, nxt_lj;
    frl_logbyte_t logo_ff, nxt_logo;

    logic cmd_acc;
    logic nvm_ok;
    assign cmd_acc = CMD_I.valid && (state_ff == ST_IDLE);
    assign nvm_ok = !hot_ff;

    always_comb begin
        nxt_hot = hot_ff;
        if (DIE_TEMP_I > TEMP_OFF_C) begin
            nxt_hot = 1'b1;
        end else if (DIE_TEMP_I < TEMP_ON_C) begin
            nxt_hot = 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            hot_ff <= 1'b0;
        end else begin
            hot_ff <= nxt_hot;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_unlock = unlock_ff;
        nxt_ptr = ptr_ff;
        nxt_sweep = sweep_ff;
        nxt_rcode = rcode_ff;
        nxt_rok = rok_ff;
        nxt_rsp = '0;
        store_go = 1'b0;
        u_we = 1'b0;
        u_waddr = ptr_ff;
        u_wdata = CMD_I.data;
        case (state_ff)
            ST_IDLE: begin
                if (cmd_acc && CMD_I.write) begin
                    case (CMD_I.code)
                        CMD_UNLOCK: begin
                            if (nvm_ok) begin
                                nxt_unlock = CMD_I.data[0];
                                nxt_ptr = '0;
                            end
                        end
                        CMD_ERASE: begin
                            if (nvm_ok && unlock_ff) begin
                                nxt_state = ST_ERASE;
                                nxt_sweep = '0;
                                nxt_ptr = '0;
                            end
                        end
                        CMD_DATA: begin
                            if (nvm_ok && unlock_ff) begin
                                u_we = 1'b1;
                                nxt_ptr = ptr_ff + 1'b1;
                            end
                        end
                        CMD_LOG_CLEAR: begin
                            if (nvm_ok) begin
                                nxt_state = ST_CLEAR;
                                nxt_sweep = '0;
                            end
                        end
                        CMD_LOG_STORE: begin
                            store_go = nvm_ok;
                        end
                        default: begin
                        end
                    endcase
                end else if (cmd_acc) begin
                    nxt_state = ST_RESP;
                    nxt_rcode = CMD_I.code;
                    nxt_rok = nvm_ok && unlock_ff;
                    if (CMD_I.code == CMD_DATA && nvm_ok && unlock_ff) begin
                        nxt_ptr = ptr_ff + 1'b1;
                    end
                end
            end
            ST_ERASE: begin
                u_we = 1'b1;
                u_waddr = sweep_ff;
                u_wdata = ERASED_WORD;
                nxt_sweep = sweep_ff + 1'b1;
                if (sweep_ff == LAST_WORD) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_CLEAR: begin
                nxt_sweep = sweep_ff + 1'b1;
                if (sweep_ff[2:0] == LOG_LAST_IDX) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_RESP: begin
                nxt_state = ST_IDLE;
                nxt_rsp.valid = 1'b1;
                case (rcode_ff)
                    CMD_UNLOCK: nxt_rsp.data = {15'h0000, unlock_ff};
                    CMD_DATA: nxt_rsp.data = rok_ff ? u_rdata : REFUSED_WORD;
                    default: nxt_rsp.data = REFUSED_WORD;
                endcase
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        nxt_busy = (nxt_state != ST_IDLE);
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state_ff <= ST_IDLE;
            unlock_ff <= 1'b0;
            ptr_ff <= '0;
            sweep_ff <= '0;
            rcode_ff <= 8'h00;
            rok_ff <= 1'b0;
            rsp_ff <= '0;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            unlock_ff <= nxt_unlock;
            ptr_ff <= nxt_ptr;
            sweep_ff <= nxt_sweep;
            rcode_ff <= nxt_rcode;
            rok_ff <= nxt_rok;
            rsp_ff <= nxt_rsp;
            busy_ff <= nxt_busy;
        end
    end

    frl_mem #(.WIDTH(16), .DEPTH(USER_WORDS)) u_user_mem (
        .clk_i(CLK_I),
        .we_i(u_we),
        .waddr_i(u_waddr),
        .wdata_i(u_wdata),
        .raddr_i(ptr_ff),
        .rdata_o(u_rdata)
    );

    // log capture: the ring keeps rolling until a fault with a known source code or a manual store freezes it
    always_comb begin
        nxt_lwp = lwp_ff;
        nxt_frozen = frozen_ff;
        nxt_pend = pend_ff;
        nxt_present = present_ff;
        nxt_src = src_ff;
        l_we = 1'b0;
        l_waddr = lwp_ff;
        l_wdata = PAGE_I;
        if (state_ff == ST_CLEAR) begin
            l_we = 1'b1;
            l_waddr = sweep_ff[2:0];
            l_wdata = '0;
            if (sweep_ff[2:0] == LOG_LAST_IDX) begin
                nxt_lwp = LOG_FIRST_IDX;
                nxt_frozen = 1'b0;
                nxt_pend = 1'b0;
                nxt_present = 1'b0;
                nxt_src = SRC_NONE;
            end
        end else if (PASS_DONE_I && !frozen_ff) begin
            l_we = 1'b1;
            nxt_lwp = ring_next(lwp_ff);
            if (pend_ff) begin
                nxt_frozen = 1'b1;
                nxt_present = 1'b1;
                nxt_pend = 1'b0;
            end
        end
        // a fault landing on the last clear cycle still arms a capture
        if (!nxt_frozen && !nxt_pend) begin
            if (FAULT_I && src_known(FAULT_CODE_I)) begin
                nxt_pend = 1'b1;
                nxt_src = FAULT_CODE_I;
            end else if (store_go) begin
                nxt_pend = 1'b1;
                nxt_src = SRC_MANUAL;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            lwp_ff <= LOG_FIRST_IDX;
            frozen_ff <= 1'b0;
            pend_ff <= 1'b0;
            present_ff <= 1'b0;
            src_ff <= SRC_NONE;
        end else begin
            lwp_ff <= nxt_lwp;
            frozen_ff <= nxt_frozen;
            pend_ff <= nxt_pend;
            present_ff <= nxt_present;
            src_ff <= nxt_src;
        end
    end

    frl_mem #(.WIDTH(PAGE_BITS), .DEPTH(LOG_PAGES)) u_log_mem (
        .clk_i(CLK_I),
        .we_i(l_we),
        .waddr_i(l_waddr),
        .wdata_i(l_wdata),
        .raddr_i(l_raddr),
        .rdata_o(l_rdata)
    );

    // log byte readout, two cycles from request to byte
    always_comb begin
        logic [7:0] off;
        off = LOG_RD_I.addr - LOG_PAGE0_BASE;
        nxt_lrv = LOG_RD_I.valid;
        nxt_lin = (LOG_RD_I.addr >= LOG_PAGE0_BASE) && (LOG_RD_I.addr <= LOG_LAST_BYTE);
        nxt_lhdr = (LOG_RD_I.addr == LOG_HDR_SRC_BYTE);
        nxt_lj = 5'(off % 8'(PAGE_BYTES));
        l_raddr = ring_back(lwp_ff, 3'(off / 8'(PAGE_BYTES)));
        nxt_logo.valid = lrv_ff;
        if (lin_ff) begin
            nxt_logo.data = page_byte(l_rdata, lj_ff);
        end else if (lhdr_ff) begin
            nxt_logo.data = src_ff;
        end else begin
            nxt_logo.data = EMPTY_BYTE;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            lrv_ff <= 1'b0;
            lin_ff <= 1'b0;
            lhdr_ff <= 1'b0;
            lj_ff <= 5'h00;
            logo_ff <= '0;
        end else begin
            lrv_ff <= nxt_lrv;
            lin_ff <= nxt_lin;
            lhdr_ff <= nxt_lhdr;
            lj_ff <= nxt_lj;
            logo_ff <= nxt_logo;
        end
    end

    assign RSP_O = rsp_ff;
    assign BUSY_O = busy_ff;
    assign LOG_O = logo_ff;
    assign NVM_BLOCKED_O = hot_ff;
    assign MFR_STATUS_O = 8'(present_ff) << MFR_LOG_PRESENT_BIT;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    sequence s_wr(logic [7:0] c);
        cmd_acc && CMD_I.write && CMD_I.code == c;
    endsequence

    sequence s_capture;
        pend_ff && !frozen_ff && state_ff != ST_CLEAR ##0 PASS_DONE_I;
    endsequence

    a_hot_gate_set: assert property (DIE_TEMP_I > TEMP_OFF_C |=> hot_ff && NVM_BLOCKED_O)
        else $error("gate not set above upper threshold");
    a_cool_hold: assert property (hot_ff && DIE_TEMP_I >= TEMP_ON_C |=> hot_ff)
        else $error("gate released above lower threshold");
    a_locked_no_write: assert property (u_we |-> (state_ff == ST_ERASE) || (unlock_ff && !hot_ff))
        else $error("user memory written while locked or hot");
    a_ptr_step: assert property (s_wr(CMD_DATA) ##0 (unlock_ff && !hot_ff)
        |=> ptr_ff == $past(ptr_ff) + 1'b1)
        else $error("pointer did not advance after word write");
    a_unlock_ptr_zero: assert property (s_wr(CMD_UNLOCK) ##0 !hot_ff |=> ptr_ff == '0)
        else $error("pointer not reset by unlock");
    a_erase_sweep: assert property (s_wr(CMD_ERASE) ##0 (unlock_ff && !hot_ff)
        |=> state_ff == ST_ERASE && BUSY_O ##1 u_we && u_wdata == ERASED_WORD)
        else $error("erase did not start its sweep");
    a_clear_drops_flag: assert property (s_wr(CMD_LOG_CLEAR) ##0 !hot_ff
        |-> ##[1:8] !present_ff && MFR_STATUS_O == 8'h00)
        else $error("log present flag not cleared");
    a_fault_freeze: assert property (s_capture |=> frozen_ff && MFR_STATUS_O[3])
        else $error("capture did not freeze the log");
    a_frozen_no_page: assert property (frozen_ff && state_ff != ST_CLEAR |-> !l_we)
        else $error("frozen log overwritten");
    a_manual_code: assert property (s_wr(CMD_LOG_STORE) ##0 (!hot_ff && !pend_ff && !frozen_ff
        && !FAULT_I) |=> pend_ff && src_ff == SRC_MANUAL)
        else $error("manual store source code wrong");
    a_read_answer: assert property (cmd_acc && !CMD_I.write |=> !RSP_O.valid ##1 RSP_O.valid)
        else $error("read answer not on second cycle");
endmodule // frl_top
`default_nettype wire

// ==== verification/frl_conv_model.sv ====
// frl_conv_model: telemetry converter stand-in, one page per full pass.
// assumes a caller on clk_i asks for each pass; page bytes follow the pass number.
`timescale 1ns/100ps
`default_nettype none
module frl_conv_model
    import frl_pkg::*;
(
    input wire logic clk_i,
    output logic pass_done_o,
    output frl_page_t page_o
);
    int passes;

    initial begin
        passes = 0;
        pass_done_o = 1'b0;
        page_o = '0;
    end

    // byte j of pass n is n*32+j, so six neighbouring pages never alias
    task automatic run_pass();
        frl_page_t pg;
        passes++;
        for (int j = 0; j < PAGE_BYTES; j++) begin
            pg[PAGE_BITS-1-8*j -: 8] = 8'(passes * 32 + j);
        end
        @(posedge clk_i);
        pass_done_o <= 1'b1;
        page_o <= pg;
        @(posedge clk_i);
        pass_done_o <= 1'b0;
        // page only holds for the pulse, so a late sample sees garbage
        page_o <= ~pg;
    endtask
endmodule // frl_conv_model
`default_nettype wire

// ==== verification/frl_top_tb_top.sv ====
// frl_top_tb_top: self-checking bench for fault record and user memory access.
// assumes frl_pkg and frl_conv_model compiled first; single 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module frl_top_tb_top
    import frl_pkg::*;
;
    localparam int UW = 16;
    logic clk = 1'b0;
    logic srst = 1'b1;
    frl_cmd_t cmd_d = '0;
    frl_rsp_t rsp;
    logic busy;
    logic signed [15:0] temp = 16'sh0019;
    logic pass_done;
    frl_page_t page;
    logic fault = 1'b0;
    logic [7:0] fcode = 8'h00;
    frl_logrd_t log_rd = '0;
    frl_logbyte_t log_b;
    logic [7:0] mfr;
    logic blocked;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rng = 32'h22c2_8141;
    logic [15:0] q_word[$];
    logic [7:0] q_byte[$];
    logic [15:0] w[UW+1];
    logic [7:0] codes[3] = '{SRC_MANUAL, SRC_CH1_BASE, SRC_CH0_LAST};

    always #5 clk = ~clk;

    frl_top #(.USER_WORDS(UW)) i_dut (
        .CLK_I(clk),
        .SRST_I(srst),
        .CMD_I(cmd_d),
        .RSP_O(rsp),
        .BUSY_O(busy),
        .DIE_TEMP_I(temp),
        .PASS_DONE_I(pass_done),
        .PAGE_I(page),
        .FAULT_I(fault),
        .FAULT_CODE_I(fcode),
        .LOG_RD_I(log_rd),
        .LOG_O(log_b),
        .MFR_STATUS_O(mfr),
        .NVM_BLOCKED_O(blocked)
    );

    frl_conv_model i_conv (
        .clk_i(clk),
        .pass_done_o(pass_done),
        .page_o(page)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] log_exp(input int a, input int nw, input logic [7:0] src);
        if (a == 0) return src;
        if (a < 27 || a > 146) return 8'h00;
        return 8'((nw - (a - 27) / 20) * 32 + (a - 27) % 20);
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic tally(input logic ok, input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (!ok) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cmp_word(input logic [15:0] g, input logic [15:0] e);
        tally(g === e, g, e);
    endtask

    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        tally(g === e, {8'h00, g}, {8'h00, e});
    endtask

    task automatic cmp_lvl(input logic [7:0] g, input logic [7:0] e);
        tally(g === e, {8'h00, g}, {8'h00, e});
    endtask

    task automatic say(input string s);
        $display("test done: %s", s);
    endtask

    // waits out BUSY_O at the falling edge so the taking edge never sees it high
    task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk);
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        cmd_d <= '{1'b1, wr, code, d};
        @(posedge clk);
        cmd_d.valid <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        q_word.push_back(e);
        cmd(1'b0, c, 16'h0000);
    endtask

    task automatic rd_log(input logic [7:0] a, input logic [7:0] e);
        q_byte.push_back(e);
        @(posedge clk);
        log_rd <= '{1'b1, a};
        @(posedge clk);
        log_rd.valid <= 1'b0;
        @(posedge clk);
    endtask

    // sel 1 watches the temperature gate, 0 the status byte; bounded poll
    task automatic lvl(input logic sel, input logic [7:0] e);
        int n;
        n = 0;
        @(negedge clk);
        while ((sel ? {7'h00, blocked} : mfr) !== e && n < 100) begin
            @(negedge clk);
            n++;
        end
        cmp_lvl(sel ? {7'h00, blocked} : mfr, e);
    endtask

    task automatic heat(input logic signed [15:0] t, input logic [7:0] e);
        @(posedge clk);
        temp <= t;
        lvl(1'b1, e);
    endtask

    task automatic pulse(input logic [7:0] c);
        @(posedge clk);
        fault <= 1'b1;
        fcode <= c;
        @(posedge clk);
        fault <= 1'b0;
        fcode <= ~c;
    endtask

    task automatic clear();
        cmd(1'b1, CMD_LOG_CLEAR, 16'h0000);
        lvl(1'b0, 8'h00);
    endtask

    always @(negedge clk) begin
        if (rsp.valid === 1'b1) begin
            cmp_word(rsp.data, (q_word.size() > 0) ? q_word.pop_front() : 16'hxxxx);
        end
        if (log_b.valid === 1'b1) begin
            cmp_byte(log_b.data, (q_byte.size() > 0) ? q_byte.pop_front() : 8'hxx);
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(CMD_DATA, REFUSED_WORD);
        cmd(1'b1, CMD_UNLOCK, 16'h0001);
        rd(CMD_UNLOCK, 16'h0001);
        cmd(1'b1, CMD_ERASE, 16'h0000);
        for (int i = 0; i < UW; i++) rd(CMD_DATA, ERASED_WORD);
        say("erase");
        cmd(1'b1, CMD_UNLOCK, 16'h0001);
        // one word past the end, so the pointer wrap lands on word 0
        for (int i = 0; i <= UW; i++) begin
            rng = xs(rng);
            w[i] = rng[15:0];
            cmd(1'b1, CMD_DATA, w[i]);
        end
        cmd(1'b1, CMD_UNLOCK, 16'h0001);
        for (int i = 0; i < UW; i++) rd(CMD_DATA, (i == 0) ? w[UW] : w[i]);
        say("word stream");
        heat(16'sh0082, 8'h00);
        heat(16'sh0083, 8'h01);
        cmd(1'b1, CMD_DATA, 16'h1234);
        cmd(1'b1, CMD_ERASE, 16'h0000);
        cmd(1'b1, CMD_UNLOCK, 16'h0000);
        heat(16'sh007D, 8'h01);
        heat(16'sh007C, 8'h00);
        rd(CMD_UNLOCK, 16'h0001);
        rd(CMD_DATA, w[UW]);
        say("temperature gate");
        cmd(1'b1, CMD_UNLOCK, 16'h0000);
        cmd(1'b1, CMD_DATA, 16'hABCD);
        rd(CMD_DATA, REFUSED_WORD);
        cmd(1'b1, CMD_UNLOCK, 16'h0001);
        rd(CMD_DATA, w[UW]);
        say("lock");
        repeat (8) i_conv.run_pass();
        pulse(8'h03);
        lvl(1'b0, 8'h00);
        i_conv.run_pass();
        lvl(1'b0, 8'h08);
        for (int a = 0; a < 151; a++) rd_log(8'(a), log_exp(a, i_conv.passes, 8'h03));
        clear();
        rd_log(8'h1B, 8'h00);
        rd_log(8'h92, 8'h00);
        // an unknown source code must not arm a capture
        pulse(8'h20);
        i_conv.run_pass();
        lvl(1'b0, 8'h00);
        for (int k = 0; k < 3; k++) begin
            if (codes[k] == SRC_MANUAL) cmd(1'b1, CMD_LOG_STORE, 16'h0000);
            else pulse(codes[k]);
            i_conv.run_pass();
            lvl(1'b0, 8'h08);
            rd_log(8'h00, codes[k]);
            clear();
        end
        say("fault record");
        repeat (5) @(posedge clk);
        cmp_lvl(8'(q_word.size() + q_byte.size()), 8'h00);
        final_report();
    end
endmodule // frl_top_tb_top
`default_nettype wire
